/* File: rtl/mss_regs.vh */
// Register map, field positions, reset values and timing counts of the start/stop sequencer.
`ifndef MSS_REGS_VH
`define MSS_REGS_VH
`define MSS_A_CTRL 8'h00
`define MSS_A_STARTF 8'h04
`define MSS_A_HOLD 8'h08
`define MSS_A_SCUR 8'h0c
`define MSS_A_STIME 8'h10
`define MSS_A_SHARE1 8'h14
`define MSS_A_SHARE2 8'h18
`define MSS_A_THR 8'h1c
`define MSS_A_BWAIT 8'h20
`define MSS_A_BCUR 8'h24
`define MSS_A_BTIME 8'h28
`define MSS_A_TARGET 8'h2c
`define MSS_A_RAMP0 8'h30
`define MSS_A_RAMP1 8'h34
`define MSS_A_RAMP2 8'h38
`define MSS_A_RAMP3 8'h3c
`define MSS_A_FB 8'h40
`define MSS_A_STATUS 8'h44
`define MSS_RUN_BIT 0
`define MSS_DIR_BIT 1
`define MSS_SMODE_LSB 4
`define MSS_RAMP_LSB 8
`define MSS_STOPM_BIT 12
`define MSS_ST_LSB 16
`define MSS_OUTEN_BIT 13
`define MSS_START_DIRECT 2'h0
`define MSS_START_TRACK 2'h1
`define MSS_START_PREEXC 2'h2
`define MSS_START_PREEXC_ALT 2'h3
`define MSS_RAMP_LINEAR 2'h0
`define MSS_RAMP_SA 2'h1
`define MSS_RAMP_SB 2'h2
`define MSS_STOP_COAST 1'h1
`define MSS_CTRL_RST 32'h00000000
`define MSS_ZERO16_RST 16'h0000
`define MSS_SHARE_RST 10'h12c
`define MSS_FB_RST 16'h1388
`define MSS_RAMPT_RST 16'h0064
`define MSS_STARTF_MAX 16'h03e8
`define MSS_T100_MAX 16'h03e8
`define MSS_T36_MAX 16'h0168
`define MSS_CUR_MAX 7'h64
`define MSS_SHARE_MAX 10'h3e8
`define MSS_SB_NUM 48'h9
`define MSS_SB_DEN 48'h8
`define MSS_SA_KMIN 9'h010
`define MSS_SA_KMAX 9'h100
`define MSS_RESP_OKAY 2'h0
`define MSS_RESP_SLVERR 2'h2
`define MSS_CLK_NS 10
`define MSS_TICK_NS 1000000
`define MSS_TICK_CYCLES (`MSS_TICK_NS / `MSS_CLK_NS)
`define MSS_TENTH_NS 100000000
`define MSS_TICKS_PER_TENTH (`MSS_TENTH_NS / `MSS_TICK_NS)
`endif

/* File: rtl/mss_sequencer.v */
// Motor start/stop sequencer with an AXI4-Lite register slave.
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "mss_regs.vh"

module mss_sequencer #(
   parameter TICK_CYCLES = `MSS_TICK_CYCLES
) (
   // Clock and reset
   input wire CLK,
   input wire NRST,
   // AXI4-Lite register slave
   input wire [7:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output reg S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output reg S_AXI_WREADY,
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [7:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output reg S_AXI_ARREADY,
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY,
   // Ramp time set terminals
   input wire [1:0] ACC_SEL,
   // Speed tracker
   input wire TRACK_VALID,
   input wire [15:0] TRACK_FREQ,
   input wire TRACK_DIR,
   // Power stage commands and tracking request
   output reg [15:0] FREQ_REF,
   output reg DIR_OUT,
   output reg OUT_EN,
   output reg DC_BRAKE,
   output reg EXCITE,
   output reg [6:0] CURRENT_CMD,
   output reg TRACK_REQ,
   output reg RUN_TIME_EN
);

   localparam [8:0] ST_IDLE = 9'h001;
   localparam [8:0] ST_SBRAKE = 9'h002;
   localparam [8:0] ST_EXCITE = 9'h004;
   localparam [8:0] ST_TRACK = 9'h008;
   localparam [8:0] ST_HOLD = 9'h010;
   localparam [8:0] ST_RUN = 9'h020;
   localparam [8:0] ST_DECEL = 9'h040;
   localparam [8:0] ST_SWAIT = 9'h080;
   localparam [8:0] ST_SDCB = 9'h100;

   function [23:0] tenth_ticks;
      input [15:0] t;
      reg [31:0] p;
      begin
         p = t * `MSS_TICKS_PER_TENTH;
         tenth_ticks = p[23:0];
      end
   endfunction

   function [15:0] clamp16;
      input [15:0] v;
      input [15:0] lim;
      begin
         clamp16 = (v > lim) ? lim : v;
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0] be;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i]) begin
               merge[i*8 +: 8] = wd[i*8 +: 8];
            end
         end
      end
   endfunction

   function [15:0] absdiff;
      input [15:0] a;
      input [15:0] b;
      begin
         absdiff = (a > b) ? a - b : b - a;
      end
   endfunction

   // Software registers.
   reg [31:0] ctrl;
   reg [15:0] startf, hold_t, stime, thr, bwait, btime, target, fb;
   reg [6:0] scur, bcur;
   reg [9:0] share1, share2;
   reg [31:0] ramp_t [0:3];

   // Bus slave state.
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire [31:0] wr_old;
   reg [31:0] wr_val;
   reg [31:0] rd_val;
   reg rd_ok, wr_ok;

   // Sequencer state.
   reg [8:0] state;
   reg [31:0] tick_cnt;
   reg tick;
   reg [23:0] tmr;
   reg [1:0] sel_meta, sel;
   reg [47:0] acc;
   reg [8:0] k;
   reg [15:0] ramp_from, aim_q;

   wire run = ctrl[`MSS_RUN_BIT];
   wire want_dir = ctrl[`MSS_DIR_BIT];
   wire [1:0] smode = ctrl[`MSS_SMODE_LSB +: 2];
   wire [1:0] shape = ctrl[`MSS_RAMP_LSB +: 2];
   wire coast = (ctrl[`MSS_STOPM_BIT] == `MSS_STOP_COAST);

   assign wr_old = (aw_addr == `MSS_A_CTRL) ? ctrl : 32'h00000000;

   // Read mux covers the whole address map; write decode covers all of it but STATUS.
   always @* begin
      rd_ok = 1'b1;
      case (S_AXI_ARADDR)
         `MSS_A_CTRL: rd_val = ctrl;
         `MSS_A_STARTF: rd_val = {16'h0000, startf};
         `MSS_A_HOLD: rd_val = {16'h0000, hold_t};
         `MSS_A_SCUR: rd_val = {25'h0000000, scur};
         `MSS_A_STIME: rd_val = {16'h0000, stime};
         `MSS_A_SHARE1: rd_val = {22'h000000, share1};
         `MSS_A_SHARE2: rd_val = {22'h000000, share2};
         `MSS_A_THR: rd_val = {16'h0000, thr};
         `MSS_A_BWAIT: rd_val = {16'h0000, bwait};
         `MSS_A_BCUR: rd_val = {25'h0000000, bcur};
         `MSS_A_BTIME: rd_val = {16'h0000, btime};
         `MSS_A_TARGET: rd_val = {16'h0000, target};
         `MSS_A_RAMP0: rd_val = ramp_t[0];
         `MSS_A_RAMP1: rd_val = ramp_t[1];
         `MSS_A_RAMP2: rd_val = ramp_t[2];
         `MSS_A_RAMP3: rd_val = ramp_t[3];
         `MSS_A_FB: rd_val = {16'h0000, fb};
         `MSS_A_STATUS: rd_val = {7'h00, state, 2'h0, OUT_EN, DIR_OUT, 12'h000};
         default: begin
            rd_val = 32'h00000000;
            rd_ok = 1'b0;
         end
      endcase
   end

   always @* begin
      wr_val = merge(wr_old, w_data, w_strb);
      case (aw_addr)
         `MSS_A_CTRL, `MSS_A_STARTF, `MSS_A_HOLD, `MSS_A_SCUR, `MSS_A_STIME,
         `MSS_A_SHARE1, `MSS_A_SHARE2, `MSS_A_THR, `MSS_A_BWAIT, `MSS_A_BCUR,
         `MSS_A_BTIME, `MSS_A_TARGET, `MSS_A_RAMP0, `MSS_A_RAMP1, `MSS_A_RAMP2,
         `MSS_A_RAMP3, `MSS_A_FB: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // The write address and write data channels are each taken on their own; the write lands one cycle after both.
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         S_AXI_AWREADY <= 1'b1;
         S_AXI_WREADY <= 1'b1;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `MSS_RESP_OKAY;
         S_AXI_ARREADY <= 1'b1;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RRESP <= `MSS_RESP_OKAY;
         S_AXI_RDATA <= 32'h00000000;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         ctrl <= `MSS_CTRL_RST;
         startf <= `MSS_ZERO16_RST;
         hold_t <= `MSS_ZERO16_RST;
         scur <= 7'h00;
         stime <= `MSS_ZERO16_RST;
         share1 <= `MSS_SHARE_RST;
         share2 <= `MSS_SHARE_RST;
         thr <= `MSS_ZERO16_RST;
         bwait <= `MSS_ZERO16_RST;
         bcur <= 7'h00;
         btime <= `MSS_ZERO16_RST;
         target <= `MSS_ZERO16_RST;
         fb <= `MSS_FB_RST;
         ramp_t[0] <= {`MSS_RAMPT_RST, `MSS_RAMPT_RST};
         ramp_t[1] <= {`MSS_RAMPT_RST, `MSS_RAMPT_RST};
         ramp_t[2] <= {`MSS_RAMPT_RST, `MSS_RAMPT_RST};
         ramp_t[3] <= {`MSS_RAMPT_RST, `MSS_RAMPT_RST};
      end else begin
         if (S_AXI_AWREADY && S_AXI_AWVALID) begin
            aw_addr <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
         end
         if (S_AXI_WREADY && S_AXI_WVALID) begin
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
            S_AXI_WREADY <= 1'b0;
         end
         if (!S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_ok ? `MSS_RESP_OKAY : `MSS_RESP_SLVERR;
            case (aw_addr)
               `MSS_A_CTRL: ctrl <= wr_val;
               `MSS_A_STARTF: startf <= clamp16(wr_val[15:0], `MSS_STARTF_MAX);
               `MSS_A_HOLD: hold_t <= clamp16(wr_val[15:0], `MSS_T100_MAX);
               `MSS_A_SCUR: scur <= (wr_val[6:0] > `MSS_CUR_MAX) ? `MSS_CUR_MAX : wr_val[6:0];
               `MSS_A_STIME: stime <= clamp16(wr_val[15:0], `MSS_T100_MAX);
               `MSS_A_SHARE1: share1 <= (wr_val[9:0] > `MSS_SHARE_MAX) ? `MSS_SHARE_MAX : wr_val[9:0];
               `MSS_A_SHARE2: share2 <= (wr_val[9:0] > `MSS_SHARE_MAX) ? `MSS_SHARE_MAX : wr_val[9:0];
               `MSS_A_THR: thr <= wr_val[15:0];
               `MSS_A_BWAIT: bwait <= clamp16(wr_val[15:0], `MSS_T36_MAX);
               `MSS_A_BCUR: bcur <= (wr_val[6:0] > `MSS_CUR_MAX) ? `MSS_CUR_MAX : wr_val[6:0];
               `MSS_A_BTIME: btime <= clamp16(wr_val[15:0], `MSS_T36_MAX);
               `MSS_A_TARGET: target <= wr_val[15:0];
               `MSS_A_RAMP0: ramp_t[0] <= wr_val;
               `MSS_A_RAMP1: ramp_t[1] <= wr_val;
               `MSS_A_RAMP2: ramp_t[2] <= wr_val;
               `MSS_A_RAMP3: ramp_t[3] <= wr_val;
               `MSS_A_FB: fb <= wr_val[15:0];
               default: ;
            endcase
         end
         if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
         end
         if (S_AXI_ARREADY && S_AXI_ARVALID) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_val;
            S_AXI_RRESP <= rd_ok ? `MSS_RESP_OKAY : `MSS_RESP_SLVERR;
         end
         if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
         end
      end
   end

   // Tick generator and terminal synchroniser.
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         tick_cnt <= 32'h00000000;
         tick <= 1'b0;
         sel_meta <= 2'h0;
         sel <= 2'h0;
      end else begin
         sel_meta <= ACC_SEL;
         sel <= sel_meta;
         tick <= (tick_cnt == TICK_CYCLES - 1);
         if (tick_cnt == TICK_CYCLES - 1) begin
            tick_cnt <= 32'h00000000;
         end else begin
            tick_cnt <= tick_cnt + 32'h00000001;
         end
      end
   end

   // Ramp engine: an accumulator gains num every tick and loses den per 0.01 Hz step.
   wire ramping = (state == ST_RUN) || (state == ST_DECEL);
   wire [15:0] aim = (state == ST_RUN && DIR_OUT == want_dir) ? target : 16'h0000;
   wire up = FREQ_REF < aim;
   wire [31:0] rset = ramp_t[sel];
   wire [15:0] rtime = up ? rset[15:0] : rset[31:16];
   wire [23:0] rticks = tenth_ticks(rtime);
   wire [47:0] den_base = {24'h000000, (rticks == 24'h000000) ? 24'h000001 : rticks};
   wire [15:0] span = absdiff(aim, ramp_from);
   wire [15:0] rem = absdiff(aim, FREQ_REF);
   wire [25:0] span_s1 = span * share1;
   wire [25:0] span_s2 = span * share2;
   wire [25:0] done_k = (span - rem) * `MSS_SHARE_MAX;
   wire [25:0] rem_k = rem * `MSS_SHARE_MAX;
   reg [47:0] num, den;

   always @* begin
      num = {32'h00000000, fb};
      den = den_base;
      case (shape)
         `MSS_RAMP_SA: begin
            num = {23'h000000, {9'h000, fb} * {16'h0000, k}};
            den = {den_base[39:0], 8'h00};
         end
         `MSS_RAMP_SB: begin
            // Slope of the quadratic time law above the rated point: 9 fb^2 / (8 f T).
            if (FREQ_REF > fb) begin
               num = `MSS_SB_NUM * ({16'h0000, fb} * {16'h0000, fb});
               den = `MSS_SB_DEN * den_base * {32'h00000000, FREQ_REF};
            end
         end
         default: ;
      endcase
   end

   wire step = ramping && (FREQ_REF != aim) && (acc >= den);

   // Sequencer.
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         state <= ST_IDLE;
         tmr <= 24'h000000;
         acc <= 48'h000000000000;
         k <= `MSS_SA_KMIN;
         ramp_from <= 16'h0000;
         aim_q <= 16'h0000;
         FREQ_REF <= 16'h0000;
         DIR_OUT <= 1'b0;
         OUT_EN <= 1'b0;
         DC_BRAKE <= 1'b0;
         EXCITE <= 1'b0;
         CURRENT_CMD <= 7'h00;
         TRACK_REQ <= 1'b0;
         RUN_TIME_EN <= 1'b0;
      end else begin
         if (tick) begin
            tmr <= tmr + 24'h000001;
         end
         aim_q <= aim;
         if (!ramping || aim != aim_q || FREQ_REF == aim) begin
            acc <= 48'h000000000000;
         end else begin
            acc <= acc + (tick ? num : 48'h000000000000) - (step ? den : 48'h000000000000);
         end
         if (aim != aim_q) begin
            ramp_from <= FREQ_REF;
            k <= `MSS_SA_KMIN;
         end else if (tick) begin
            // Slope eases in over the start share and out over the end share.
            if (rem_k <= span_s2) begin
               k <= (k > `MSS_SA_KMIN) ? k - 9'h001 : k;
            end else if (done_k < span_s1) begin
               k <= (k < `MSS_SA_KMAX) ? k + 9'h001 : k;
            end else begin
               k <= `MSS_SA_KMAX;
            end
         end
         if (step) begin
            FREQ_REF <= up ? FREQ_REF + 16'h0001 : FREQ_REF - 16'h0001;
         end
         RUN_TIME_EN <= (state == ST_HOLD) || ramping;
         case (state)
            ST_IDLE: begin
               OUT_EN <= 1'b0;
               DC_BRAKE <= 1'b0;
               EXCITE <= 1'b0;
               CURRENT_CMD <= 7'h00;
               FREQ_REF <= 16'h0000;
               tmr <= 24'h000000;
               if (run && target != 16'h0000 && target >= startf) begin
                  DIR_OUT <= want_dir;
                  OUT_EN <= 1'b1;
                  case (smode)
                     `MSS_START_DIRECT: begin
                        if (stime != 16'h0000) begin
                           state <= ST_SBRAKE;
                           DC_BRAKE <= 1'b1;
                           CURRENT_CMD <= scur;
                        end else begin
                           state <= ST_HOLD;
                           FREQ_REF <= startf;
                        end
                     end
                     `MSS_START_TRACK: begin
                        state <= ST_TRACK;
                        TRACK_REQ <= 1'b1;
                     end
                     default: begin
                        // Code 3 is accepted as a pre-excited start alias.
                        if (stime != 16'h0000) begin
                           state <= ST_EXCITE;
                           EXCITE <= 1'b1;
                           CURRENT_CMD <= scur;
                        end else begin
                           state <= ST_HOLD;
                           FREQ_REF <= startf;
                        end
                     end
                  endcase
               end
            end
            ST_SBRAKE, ST_EXCITE: begin
               if (!run) begin
                  state <= ST_IDLE;
                  OUT_EN <= 1'b0;
               end else if (tmr >= tenth_ticks(stime)) begin
                  state <= ST_HOLD;
                  tmr <= 24'h000000;
                  DC_BRAKE <= 1'b0;
                  EXCITE <= 1'b0;
                  CURRENT_CMD <= 7'h00;
                  FREQ_REF <= startf;
               end
            end
            ST_TRACK: begin
               if (!run) begin
                  state <= ST_IDLE;
                  TRACK_REQ <= 1'b0;
               end else if (TRACK_VALID) begin
                  state <= ST_RUN;
                  TRACK_REQ <= 1'b0;
                  FREQ_REF <= TRACK_FREQ;
                  DIR_OUT <= TRACK_DIR;
               end
            end
            ST_HOLD: begin
               if (!run) begin
                  state <= coast ? ST_IDLE : ST_DECEL;
               end else if (tmr >= tenth_ticks(hold_t)) begin
                  state <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (!run) begin
                  state <= coast ? ST_IDLE : ST_DECEL;
               end else if (DIR_OUT != want_dir && FREQ_REF == 16'h0000) begin
                  DIR_OUT <= want_dir;
                  FREQ_REF <= startf;
               end
            end
            ST_DECEL: begin
               tmr <= 24'h000000;
               if (run) begin
                  state <= ST_RUN;
               end else if (btime != 16'h0000 && FREQ_REF < thr) begin
                  state <= ST_SWAIT;
                  OUT_EN <= 1'b0;
                  FREQ_REF <= 16'h0000;
               end else if (FREQ_REF == 16'h0000) begin
                  state <= ST_IDLE;
               end
            end
            ST_SWAIT: begin
               if (tmr >= tenth_ticks(bwait)) begin
                  state <= ST_SDCB;
                  tmr <= 24'h000000;
                  OUT_EN <= 1'b1;
                  DC_BRAKE <= 1'b1;
                  CURRENT_CMD <= bcur;
               end
            end
            ST_SDCB: begin
               if (tmr >= tenth_ticks(btime)) begin
                  state <= ST_IDLE;
                  OUT_EN <= 1'b0;
                  DC_BRAKE <= 1'b0;
                  CURRENT_CMD <= 7'h00;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

endmodule

/* File: verif/mss_motor.sv */
// Behavioural motor that answers speed tracking requests after a set delay.
`timescale 1ns/10ps
module mss_motor #(
   parameter [15:0] SPEED = 16'h02bc
) (
   // Clock and reset
   input wire CLK,
   input wire NRST,
   // Tracking handshake
   input wire [7:0] DELAY,
   input wire TRACK_REQ,
   output logic TRACK_VALID,
   output logic [15:0] TRACK_FREQ,
   output logic TRACK_DIR
);
   logic [7:0] cnt;
   // Outside a result the speed lines toggle, so a stale value never passes for a fresh one.
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         cnt <= 8'h00;
         TRACK_VALID <= 1'b0;
         TRACK_FREQ <= 16'h0000;
         TRACK_DIR <= 1'b0;
      end else if (TRACK_REQ && cnt == DELAY) begin
         TRACK_VALID <= 1'b1;
         TRACK_FREQ <= SPEED;
         TRACK_DIR <= 1'b0;
      end else begin
         cnt <= TRACK_REQ ? cnt + 8'h01 : 8'h00;
         TRACK_VALID <= 1'b0;
         TRACK_FREQ <= ~TRACK_FREQ;
         TRACK_DIR <= ~TRACK_DIR;
      end
   end
endmodule

/* File: verif/mss_sequencer_monitor.sv */
// Checker of the sequencer's bus handshakes and power stage commands.
`timescale 1ns/10ps
module mss_monitor (
   // Clock and reset
   input wire CLK,
   input wire NRST,
   // Register bus
   input wire S_AXI_AWVALID,
   input wire S_AXI_AWREADY,
   input wire S_AXI_WVALID,
   input wire S_AXI_WREADY,
   input wire [1:0] S_AXI_BRESP,
   input wire S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire S_AXI_ARVALID,
   input wire S_AXI_ARREADY,
   input wire [31:0] S_AXI_RDATA,
   input wire S_AXI_RVALID,
   input wire S_AXI_RREADY,
   // Power stage and tracker
   input wire TRACK_VALID,
   input wire [15:0] FREQ_REF,
   input wire OUT_EN,
   input wire DC_BRAKE,
   input wire EXCITE,
   input wire [6:0] CURRENT_CMD,
   input wire TRACK_REQ
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   sequence s_wr_taken;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence s_track_done;
      TRACK_REQ && TRACK_VALID;
   endsequence
   property p_wr_resp;
      s_wr_taken |-> ##[1:2] S_AXI_BVALID;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
   property p_b_hold;
      S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_rd_resp;
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY;
   endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
   property p_r_hold;
      S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_brake_still;
      DC_BRAKE |-> FREQ_REF == 16'h0000 && !EXCITE;
   endproperty
   a_brake_still: assert property (p_brake_still) else $error("braking with output");
   property p_excite_still;
      EXCITE |-> FREQ_REF == 16'h0000;
   endproperty
   a_excite_still: assert property (p_excite_still) else $error("exciting with output");
   property p_cur_max;
      DC_BRAKE || EXCITE |-> CURRENT_CMD <= 7'h64;
   endproperty
   a_cur_max: assert property (p_cur_max) else $error("current above full scale");
   property p_off_zero;
      !OUT_EN && !$rose(DC_BRAKE) |-> FREQ_REF == 16'h0000;
   endproperty
   a_off_zero: assert property (p_off_zero) else $error("frequency while off");
   property p_track_end;
      s_track_done |-> ##[1:3] !TRACK_REQ;
   endproperty
   a_track_end: assert property (p_track_end) else $error("tracking request stuck");
endmodule
bind mss_sequencer mss_monitor u_mon (.CLK(CLK), .NRST(NRST), .S_AXI_AWVALID(S_AXI_AWVALID),
   .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
   .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .TRACK_VALID(TRACK_VALID),
   .FREQ_REF(FREQ_REF), .OUT_EN(OUT_EN), .DC_BRAKE(DC_BRAKE), .EXCITE(EXCITE),
   .CURRENT_CMD(CURRENT_CMD), .TRACK_REQ(TRACK_REQ));

/* File: verif/tb_top.sv */
// Self-checking bench for the motor start/stop sequencer.
`timescale 1ns/10ps
`include "mss_regs.vh"
module tb_top;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, delay = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire awready, wready, bvalid, arready, rvalid, tvalid, tdir, dir, outen, brake, excite, treq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [15:0] tfreq, freq;
   wire [6:0] cur;
   wire rte;
   int checks = 0;
   int failures = 0;
   int cyc = 0;
   mss_sequencer #(.TICK_CYCLES(10)) DUT (.CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .ACC_SEL(2'h0),
      .TRACK_VALID(tvalid), .TRACK_FREQ(tfreq), .TRACK_DIR(tdir), .FREQ_REF(freq),
      .DIR_OUT(dir), .OUT_EN(outen), .DC_BRAKE(brake), .EXCITE(excite), .CURRENT_CMD(cur),
      .TRACK_REQ(treq), .RUN_TIME_EN(rte));
   mss_motor u_motor (.CLK(clk), .NRST(nrst), .DELAY(delay), .TRACK_REQ(treq),
      .TRACK_VALID(tvalid), .TRACK_FREQ(tfreq), .TRACK_DIR(tdir));
   initial forever #5 clk = ~clk;
   function automatic logic [31:0] sig(input int s);
      case (s)
         0: return {16'h0, freq};
         1: return {31'h0, brake};
         2: return {31'h0, excite};
         3: return {31'h0, treq};
         4: return {31'h0, outen};
         6: return {31'h0, rte};
         default: return {25'h0, cur};
      endcase
   endfunction
   task automatic summarize();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic await(input int s, input logic [31:0] e, input int n);
      int i;
      i = 0;
      while (sig(s) !== e && i < n) begin
         @(posedge clk);
         i++;
      end
      chk(sig(s), e);
   endtask
   // Each access starts one edge late so a strobe is never lowered and raised in one step.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w;
      @(posedge clk);
      aw = 1'b0;
      w = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge clk);
         aw = aw || awready === 1'b1;
         w = w || wready === 1'b1;
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata, e);
      chk({30'h0, rresp}, {30'h0, er});
   endtask
   task automatic stop_coast(input logic [1:0] m);
      wr(`MSS_A_CTRL, {16'h0, 4'h1, 6'h0, m, 4'h0}, 2'h0);
      await(4, 32'h0, 10);
      chk(sig(0), 32'h0);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         failures++;
         summarize();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      rd(`MSS_A_STATUS, 32'h00010000, 2'h0);
      rd(`MSS_A_SHARE1, 32'h0000012c, 2'h0);
      rd(`MSS_A_STARTF, 32'h0, 2'h0);
      rd(8'h48, 32'h0, 2'h2);
      wr(8'h48, 32'h0, 2'h2);
      wr(`MSS_A_STARTF, 32'h000007d0, 2'h0);
      rd(`MSS_A_STARTF, 32'h000003e8, 2'h0);
      wr(`MSS_A_STIME, 32'h00001388, 2'h0);
      rd(`MSS_A_STIME, 32'h000003e8, 2'h0);
      wr(`MSS_A_BWAIT, 32'h00000400, 2'h0);
      rd(`MSS_A_BWAIT, 32'h00000168, 2'h0);
      $display("test ranges finished");
      wr(`MSS_A_STARTF, 32'h1f4, 2'h0);
      wr(`MSS_A_RAMP0, 32'h00010001, 2'h0);
      wr(`MSS_A_TARGET, 32'hc8, 2'h0);
      wr(`MSS_A_CTRL, 32'h1, 2'h0);
      repeat (300) @(posedge clk);
      chk(sig(0), 32'h0);
      chk(sig(4), 32'h0);
      wr(`MSS_A_CTRL, 32'h0, 2'h0);
      wr(`MSS_A_TARGET, 32'h3e8, 2'h0);
      wr(`MSS_A_STIME, 32'h1, 2'h0);
      wr(`MSS_A_SCUR, 32'h32, 2'h0);
      wr(`MSS_A_CTRL, 32'h1, 2'h0);
      await(1, 32'h1, 30);
      chk(sig(5), 32'h32);
      await(0, 32'h1f4, 1500);
      await(0, 32'h3e8, 3000);
      stop_coast(2'h0);
      wr(`MSS_A_CTRL, 32'h00000001, 2'h0);
      await(1, 32'h1, 30);
      wr(`MSS_A_CTRL, 32'h0, 2'h0);
      await(1, 32'h0, 10);
      $display("test direct start finished");
      for (int m = 2; m < 4; m++) begin
         wr(`MSS_A_CTRL, {26'h0, m[1:0], 4'h1}, 2'h0);
         await(2, 32'h1, 30);
         chk(sig(1), 32'h0);
         chk(sig(5), 32'h32);
         await(0, 32'h3e8, 4000);
         stop_coast(m[1:0]);
      end
      wr(`MSS_A_STIME, 32'h0, 2'h0);
      wr(`MSS_A_CTRL, 32'h00000021, 2'h0);
      await(0, 32'h1f4, 40);
      chk(sig(2), 32'h0);
      stop_coast(2'h2);
      $display("test pre-excited start finished");
      for (int d = 0; d < 50; d += 40) begin
         delay <= d[7:0];
         wr(`MSS_A_CTRL, 32'h00000011, 2'h0);
         await(3, 32'h1, 30);
         await(0, 32'h2bc, 200);
         stop_coast(2'h1);
      end
      $display("test tracking finished");
      wr(`MSS_A_THR, 32'h258, 2'h0);
      wr(`MSS_A_BWAIT, 32'h1, 2'h0);
      wr(`MSS_A_BCUR, 32'h28, 2'h0);
      wr(`MSS_A_BTIME, 32'h1, 2'h0);
      wr(`MSS_A_HOLD, 32'h1, 2'h0);
      wr(`MSS_A_CTRL, 32'h101, 2'h0);
      await(6, 32'h1, 40);
      repeat (900) @(posedge clk);
      chk(sig(0), 32'h1f4);
      await(0, 32'h3e8, 3000);
      wr(`MSS_A_CTRL, 32'h3, 2'h0);
      await(0, 32'h0, 2000);
      await(0, 32'h3e8, 900);
      wr(`MSS_A_CTRL, 32'h0, 2'h0);
      await(4, 32'h0, 2000);
      chk(sig(0), 32'h0);
      chk(sig(1), 32'h0);
      await(1, 32'h1, 1200);
      chk(sig(5), 32'h28);
      await(1, 32'h0, 1200);
      rd(`MSS_A_STATUS, 32'h00011000, 2'h0);
      $display("test stop braking finished");
      summarize();
   end
endmodule
